// ### hdl/esc_pkg.sv
/*
 * constants for the elapsed seconds counter with three-wire serial port.
 * assumes a single core clock at 125 MHz; serial pins are asynchronous to it.
 */
`default_nettype none
package esc_pkg;
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 32;
    localparam int BIT_RD = 0;
    localparam int BIT_CLR_PWR = 1;
    localparam int BIT_CLR_CONT = 2;
    localparam int BIT_TRIM_LO = 3;
    localparam int BIT_TRIM_HI = 5;
    localparam int BIT_SEL_PWR = 6;
    localparam int BIT_SEL_CONT = 7;
    localparam logic [2:0] TRIM_RESET = 3'h3;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_HZ = 1;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int TRIM_STEP = 16;
    localparam logic [5:0] BITCNT_CMD_DONE = 6'h08;
    localparam logic [5:0] BITCNT_DATA_DONE = 6'h28;
    typedef enum logic [1:0] {ESC_IDLE, ESC_CMD, ESC_DATA, ESC_DONE} esc_state_t;
endpackage : esc_pkg
`default_nettype wire

// ### hdl/esc_tick_gen.sv
/*
 * one-second tick divider with trim; stands in for the trimmed crystal.
 * assumes core_clk at the package rate; trim 0 stops ticks.
 */
`timescale 1ns/1ns
`default_nettype none
module esc_tick_gen #(
    parameter int TICK_CYCLES = esc_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [2:0] trim,
    output logic tick
);
    logic [31:0] cnt_ff;
    logic [31:0] period;
    wire osc_run = (trim != 3'h0);
    // higher trim shortens the period, so counting runs faster
    assign period = 32'(TICK_CYCLES) + 32'(esc_pkg::TRIM_STEP) * (32'h3 - 32'(trim));
    wire wrap = (cnt_ff + 32'h1 >= period);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 32'h0;
            tick <= 1'b0;
        end else if (!osc_run) begin
            tick <= 1'b0;
        end else begin
            cnt_ff <= wrap ? 32'h0 : cnt_ff + 32'h1;
            tick <= wrap;
        end
    end
endmodule : esc_tick_gen
`default_nettype wire

// ### hdl/esc_serial_counter.sv
/*
 * two seconds counters behind a three-wire serial port, with trim register.
 * assumes serial pins are asynchronous and slow against core_clk (8 ns).
 */
`timescale 1ns/1ns
`default_nettype none
module esc_serial_counter #(
    parameter int TICK_CYCLES = esc_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic xfer_en,
    input wire logic ser_clk,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe,
    input wire logic main_supply_ok,
    output logic [31:0] continuous_seconds,
    output logic [31:0] powered_seconds
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] en_sync_ff;
    logic [1:0] clk_sync_ff;
    logic [1:0] dq_sync_ff;
    logic [1:0] pwr_sync_ff;
    logic en_q_ff;
    logic clk_q_ff;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_sync_ff <= 2'h0;
            clk_sync_ff <= 2'h0;
            dq_sync_ff <= 2'h0;
            pwr_sync_ff <= 2'h0;
            en_q_ff <= 1'b0;
            clk_q_ff <= 1'b0;
        end else begin
            en_sync_ff <= {en_sync_ff[0], xfer_en};
            clk_sync_ff <= {clk_sync_ff[0], ser_clk};
            dq_sync_ff <= {dq_sync_ff[0], dq_in};
            pwr_sync_ff <= {pwr_sync_ff[0], main_supply_ok};
            en_q_ff <= en_sync_ff[1];
            clk_q_ff <= clk_sync_ff[1];
        end
    end
    wire pwr_ok = pwr_sync_ff[1];
    wire port_en = en_sync_ff[1] && pwr_ok;
    wire en_fall = en_q_ff && !en_sync_ff[1];
    wire sclk_rise = clk_sync_ff[1] && !clk_q_ff;
    wire sclk_fall = !clk_sync_ff[1] && clk_q_ff;
    wire sclk_lvl = clk_sync_ff[1];
    wire sdata = dq_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // protocol state
    esc_pkg::esc_state_t state_ff;
    esc_pkg::esc_state_t nxt_state;
    logic [5:0] bitcnt_ff;
    logic [7:0] cmd_ff;
    logic [31:0] shift_ff;
    logic [2:0] trim_ff;
    logic [31:0] cont_ff;
    logic [31:0] pwr_cnt_ff;
    logic [7:0] nxt_cmd;
    logic tick;

    assign nxt_cmd = {sdata, cmd_ff[7:1]};
    wire sel_cont = nxt_cmd[esc_pkg::BIT_SEL_CONT];
    wire sel_pwr = nxt_cmd[esc_pkg::BIT_SEL_PWR];
    wire cmd_last = sclk_rise && (bitcnt_ff == esc_pkg::BITCNT_CMD_DONE - 6'h1);
    wire cmd_trim = cmd_last && sel_cont && sel_pwr;
    wire cmd_xfer = cmd_last && (sel_cont ^ sel_pwr);
    wire cmd_read = cmd_xfer && nxt_cmd[esc_pkg::BIT_RD];
    wire c_cont = cmd_ff[esc_pkg::BIT_SEL_CONT];
    wire c_read = cmd_ff[esc_pkg::BIT_RD];
    wire data_rise = (state_ff == esc_pkg::ESC_DATA) && sclk_rise;
    wire data_last = data_rise && (bitcnt_ff == esc_pkg::BITCNT_DATA_DONE - 6'h1);
    wire wr_load = data_last && !c_read;
    wire [31:0] wr_word = {sdata, shift_ff[31:1]};
    wire clr_cmd = (state_ff != esc_pkg::ESC_IDLE) && (state_ff != esc_pkg::ESC_CMD)
                   && !c_cont && !cmd_ff[esc_pkg::BIT_SEL_PWR];
    wire clr_cont = en_fall && clr_cmd && cmd_ff[esc_pkg::BIT_CLR_CONT];
    wire clr_pwr = en_fall && clr_cmd && cmd_ff[esc_pkg::BIT_CLR_PWR];

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            esc_pkg::ESC_IDLE: if (port_en) nxt_state = esc_pkg::ESC_CMD;
            esc_pkg::ESC_CMD: begin
                if (cmd_xfer) nxt_state = esc_pkg::ESC_DATA;
                else if (cmd_last) nxt_state = esc_pkg::ESC_DONE;
            end
            esc_pkg::ESC_DATA: if (data_last) nxt_state = esc_pkg::ESC_DONE;
            esc_pkg::ESC_DONE: nxt_state = esc_pkg::ESC_DONE;
            default: nxt_state = esc_pkg::ESC_IDLE;
        endcase
        if (!port_en) nxt_state = esc_pkg::ESC_IDLE;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= esc_pkg::ESC_IDLE;
            bitcnt_ff <= 6'h0;
            cmd_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state == esc_pkg::ESC_IDLE) bitcnt_ff <= 6'h0;
            else if (sclk_rise && state_ff != esc_pkg::ESC_DONE) bitcnt_ff <= bitcnt_ff + 6'h1;
            if (nxt_state == esc_pkg::ESC_IDLE && state_ff == esc_pkg::ESC_IDLE) cmd_ff <= 8'h00;
            else if (state_ff == esc_pkg::ESC_CMD && sclk_rise) cmd_ff <= nxt_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data shifter: holds read copy or write buffer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= esc_pkg::COUNT_RESET;
        end else if (cmd_read) begin
            shift_ff <= sel_cont ? cont_ff : pwr_cnt_ff;
        end else if (state_ff == esc_pkg::ESC_DATA && c_read && sclk_fall
                     && bitcnt_ff != esc_pkg::BITCNT_CMD_DONE) begin
            shift_ff <= {1'b0, shift_ff[31:1]};
        end else if (data_rise && !c_read) begin
            shift_ff <= wr_word;
        end
    end

    // bit 0 appears at the first fall after the command; later falls advance
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= 1'b0;
            dq_oe <= 1'b0;
        end else begin
            dq_out <= shift_ff[0];
            // held off during the shift cycle so the pin never shows a moving bit
            dq_oe <= (state_ff == esc_pkg::ESC_DATA) && c_read && port_en && !sclk_fall
                     && !sclk_lvl && nxt_state == esc_pkg::ESC_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counters and trim
    esc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .trim(trim_ff),
        .tick(tick)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            trim_ff <= esc_pkg::TRIM_RESET;
            cont_ff <= esc_pkg::COUNT_RESET;
            pwr_cnt_ff <= esc_pkg::COUNT_RESET;
        end else begin
            if (cmd_trim) trim_ff <= nxt_cmd[esc_pkg::BIT_TRIM_HI:esc_pkg::BIT_TRIM_LO];
            if (clr_cont) cont_ff <= esc_pkg::COUNT_RESET;
            else if (wr_load && c_cont) cont_ff <= wr_word;
            else if (tick) cont_ff <= cont_ff + 32'h1;
            if (clr_pwr) pwr_cnt_ff <= esc_pkg::COUNT_RESET;
            else if (wr_load && !c_cont) pwr_cnt_ff <= wr_word;
            else if (tick && pwr_ok) pwr_cnt_ff <= pwr_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            continuous_seconds <= esc_pkg::COUNT_RESET;
            powered_seconds <= esc_pkg::COUNT_RESET;
        end else begin
            continuous_seconds <= cont_ff;
            powered_seconds <= pwr_cnt_ff;
        end
    end
endmodule : esc_serial_counter
`default_nettype wire

// ### verif/esc_serial_counter_monitor.sv
/* port checker for esc_serial_counter; bound to every instance of it. */
`timescale 1ns/1ns
`default_nettype none
module esc_serial_counter_monitor #(parameter int TICK_CYCLES = esc_pkg::TICK_CYCLES) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic xfer_en,
    input wire logic ser_clk,
    input wire logic dq_out,
    input wire logic dq_oe,
    input wire logic main_supply_ok,
    input wire logic [31:0] continuous_seconds,
    input wire logic [31:0] powered_seconds
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_abort_off: assert property (!xfer_en [*6] |-> !dq_oe)
        else $error("pin held after abort");
    a_clk_high: assert property ($rose(ser_clk) |-> ##3 !dq_oe)
        else $error("pin driven, clock high");
    a_backup_off: assert property (!main_supply_ok [*6] |-> !dq_oe)
        else $error("pin driven in backup");
    a_bit_hold: assert property (dq_oe && $past(dq_oe) |-> $stable(dq_out))
        else $error("read bit moved");
    a_cont_inc: assert property (!xfer_en [*8] ##1 $changed(continuous_seconds) |->
        continuous_seconds == $past(continuous_seconds) + 32'h1) else $error("bad step");
    a_pwr_inc: assert property (!xfer_en [*8] ##1 $changed(powered_seconds) |->
        powered_seconds == $past(powered_seconds) + 32'h1) else $error("bad step");
    a_pwr_stop: assert property ((!xfer_en && !main_supply_ok) [*8] |=>
        $stable(powered_seconds)) else $error("count in backup");
    a_pwr_pair: assert property ((!xfer_en && main_supply_ok) [*8] ##1
        $changed(continuous_seconds) |-> $changed(powered_seconds)) else $error("tick lost");
endmodule : esc_serial_counter_monitor
bind esc_serial_counter esc_serial_counter_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
    .core_clk, .rst_b, .xfer_en, .ser_clk, .dq_out, .dq_oe, .main_supply_ok,
    .continuous_seconds, .powered_seconds);
`default_nettype wire

// ### verif/esc_host_model.sv
/* host model framing the serial pins; assumes an 8 ns core_clk. */
`timescale 1ns/1ns
`default_nettype none
module esc_host_model (
    input wire logic core_clk,
    input wire logic dq_out,
    input wire logic dq_oe,
    output logic xfer_en,
    output logic ser_clk,
    output logic dq_in
);
    logic drv;
    assign dq_in = dq_oe ? dq_out : drv;
    initial {xfer_en, ser_clk, drv} = 3'h0;
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, input int nd,
        output logic [31:0] rd);
        @(negedge core_clk) xfer_en = 1'h1;
        for (int k = 0; k < 8 + nd; k++) begin
            drv = (k > 7 && cmd[0]) ? ~drv : (k < 8) ? cmd[k] : wd[(k - 8) % 32] ^ (k > 39);
            #32;
            if (k > 7 && k < 40) rd[k - 8] = dq_in;
            ser_clk = 1'h1;
            #32;
            if (k < 7 + nd) ser_clk = 1'h0;
        end
        xfer_en = 1'h0;
        #48;
        ser_clk = 1'h0;
    endtask : xfer
endmodule : esc_host_model
`default_nettype wire

// ### verif/esc_serial_counter_test.sv
/* bench for esc_serial_counter; needs the host model, tick cut to 200. */
`timescale 1ns/1ns
`default_nettype none
module esc_serial_counter_test;
    logic core_clk, rst_b, main_supply_ok, xfer_en, ser_clk, dq_in, dq_out, dq_oe;
    logic [31:0] cont, pwr, rd;
    int err_count = 0, n_compared = 0;
    esc_serial_counter #(.TICK_CYCLES(200)) i_esc_serial_counter (.core_clk, .rst_b, .xfer_en,
        .ser_clk, .dq_in, .dq_out, .dq_oe, .main_supply_ok, .continuous_seconds(cont),
        .powered_seconds(pwr));
    esc_host_model i_esc_host_model (.core_clk, .dq_out, .dq_oe, .xfer_en, .ser_clk, .dq_in);
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        err_count += int'(got !== exp);
        if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask : chk
    task automatic go(input logic [7:0] c, input logic [31:0] w, input int n);
        i_esc_host_model.xfer(c, w, n, rd);
    endtask : go
    task automatic t_serial;
        go(8'hC0, 32'h0, 0);
        go(8'h80, 32'hA5C3_0F1E, 32);
        go(8'hC0, 32'h1234_5678, 32);
        go(8'h40, 32'h0BAD_F00D, 40);
        go(8'h80, 32'hFFFF_FFFF, 16);
        #4800;
        chk(cont, 32'hA5C3_0F1E);
        chk(pwr, 32'h0BAD_F00D);
        go(8'h81, 32'h0, 32);
        chk(rd, 32'hA5C3_0F1E);
        go(8'h06, 32'h0, 0);
        chk(cont | pwr, 32'h0);
        $display("serial test end");
    endtask : t_serial
    task automatic t_backup;
        go(8'hD8, 32'h0, 0);
        #4800;
        main_supply_ok = 1'h0;
        #4800;
        go(8'h80, 32'h0, 32);
        chk({31'h0, cont > pwr + 32'h1}, 32'h1);
        main_supply_ok = 1'h1;
        $display("backup test end");
    endtask : t_backup
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        {rst_b, main_supply_ok} = 2'h1;
        #128;
        rst_b = 1'h1;
        t_serial();
        t_backup();
        test_done();
    end
    initial begin
        #160000;
        err_count++;
        test_done();
    end
endmodule : esc_serial_counter_test
`default_nettype wire
